// ---- hw/rxsc_consts.svh ----
`ifndef RXSC_CONSTS_SVH
`define RXSC_CONSTS_SVH

// Clock and time base
`define RXSC_CLK_HZ          25000000
`define RXSC_TICK_US         1000
`define RXSC_TICK_CYCLES     ((`RXSC_CLK_HZ / 1000000) * `RXSC_TICK_US)
`define RXSC_TICK_MS         1

// Timer figures in milliseconds, and their tick counts
`define RXSC_ADV_FAST_MS     100
`define RXSC_ADV_DONE_MIN_MS 600
`define RXSC_ADV_DONE_MAX_MS 800
`define RXSC_HV_HOLD_MS      5000
`define RXSC_ALERT_MS        250
`define RXSC_LINK_SUP_MS     1000
`define RXSC_TERM_MS         500
`define RXSC_CNT_W           13
`define RXSC_ADV_DONE_TICKS  (`RXSC_ADV_DONE_MIN_MS / `RXSC_TICK_MS)
`define RXSC_HV_HOLD_TICKS   (`RXSC_HV_HOLD_MS / `RXSC_TICK_MS)
`define RXSC_LINK_SUP_TICKS  (`RXSC_LINK_SUP_MS / `RXSC_TICK_MS)

// System error codes
`define RXSC_ERR_W           5
`define RXSC_ERR_NONE        5'h00
`define RXSC_ERR_OVER_VOLT   5'h01
`define RXSC_ERR_OVER_TEMP   5'h02
`define RXSC_ERR_OVER_CURR   5'h03
`define RXSC_ERR_WRONG_NET   5'h04

`endif

// ---- hw/rxsc_pkg.sv ----
`include "rxsc_consts.svh"

package rxsc_pkg;

  typedef enum logic [3:0] {
    RXSC_NULL   = 4'h1,
    RXSC_BOOT   = 4'h2,
    RXSC_ON     = 4'h4,
    RXSC_SYSERR = 4'h8
  } rxsc_state_type;

  typedef enum logic [3:0] {
    RXSC_SUB_NONE = 4'h1,
    RXSC_SUB_LOW  = 4'h2,
    RXSC_SUB_OPT  = 4'h4,
    RXSC_SUB_HIGH = 4'h8
  } rxsc_sub_type;

  typedef struct packed {
    rxsc_state_type           state;
    rxsc_sub_type             sub;
    logic [`RXSC_ERR_W-1:0]   err_code;
    logic                     ctrl_en;
    logic                     permit;
    logic                     reduce;
    logic                     conn_d;
    logic [`RXSC_CNT_W-1:0]   cont_cnt;
    logic [`RXSC_CNT_W-1:0]   hv_cnt;
    logic                     hv_run;
    logic                     hv_done;
    logic [`RXSC_CNT_W-1:0]   sup_cnt;
    logic                     sup_run;
    logic                     out_kill;
    logic                     term_sent;
    logic                     adv;
    logic                     alert;
    logic                     reconnect;
    logic                     terminate;
    logic                     charge_en;
    logic                     comm_en;
    logic                     hv_hold;
    logic                     pwr_limit;
  } rxsc_regs_type;

endpackage

// ---- hw/rxsc_tick_if.sv ----
`timescale 1ns/100ps
`default_nettype none

interface rxsc_tick_if;
  logic tick;
  modport src (output tick);
  modport snk (input  tick);
endinterface

`default_nettype wire

// ---- hw/rxsc_tick.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "rxsc_consts.svh"

// Fixed-rate millisecond tick from the system clock
module rxsc_tick
  import rxsc_pkg::*;
#(
  parameter int unsigned CYCLES = `RXSC_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic  i_clk,
  input  wire logic  i_rst_n,
  // Tick out
  rxsc_tick_if.src   tick_if
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } rxsc_tick_regs_type;

  rxsc_tick_regs_type r_ff;
  rxsc_tick_regs_type nxt_r;

  always_comb begin
    nxt_r      = r_ff;
    nxt_r.tick = 1'b0;
    if (r_ff.cnt >= CYCLES - 1) begin
      nxt_r.cnt  = 32'h0;
      nxt_r.tick = 1'b1;
    end else begin
      nxt_r.cnt = r_ff.cnt + 32'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign tick_if.tick = r_ff.tick;

endmodule

`default_nettype wire

// ---- hw/rxsc_top.sv ----
// What this block does
// - After start-up, stay in Null while rectified voltage is below boot threshold.
// - Once out of Null, return to Null when voltage falls below undervoltage lockout.
// - Charge output is disabled at start-up.
// - Unlinked, charging not done: advertise within 100 ms of coil current rising.
// - Unlinked, charging done: advertise after 600 ms steady coil current, within 800 ms.
// - Limit draw below 1.1 W unless permitted, and whenever the transmitter says so.
// - While on: Low Voltage between boot and min, Optimum between min and high.
// - High Voltage sub-state when voltage is above high and at most maximum.
// - In High Voltage keep output connected five seconds from reporting it.
// - Local fault keeps communication, raises no system error, may cut output.
// - Boot or On enter System Error on over-voltage, over-current or over-temperature.
// - System Error shuts output off until cleared, except when caused by over-voltage.
// - Send an alert within 250 ms of entering System Error.
// - In System Error with power present, notifications stay possible.
// - Only the listed state transitions are made.
// - Null goes to Boot when voltage reaches the boot threshold.
// - Boot goes to On when the transmitter writes the control value.
// - On goes back to Boot on disconnect after charging-done was sent.
// - Boot, On or System Error go to Null when power is removed.
// - System Error only for conditions that cannot be handled locally.
// - Error codes: 1 over-voltage, 2 over-temperature, 3 over-current, 4 wrong network.
// - Link supervision: one second timer, restarted by messages; expiry reconnects.
// - Linked and below boot threshold: start terminating within 500 ms.
`timescale 1ns/100ps
`default_nettype none
`include "rxsc_consts.svh"

module rxsc_top
  import rxsc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `RXSC_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_rst_n,
  // Rectified voltage comparators
  input  wire logic                    i_rectified_voltage_ge_boot,
  input  wire logic                    i_rectified_voltage_ge_uvlo,
  input  wire logic                    i_rectified_voltage_ge_min,
  input  wire logic                    i_rectified_voltage_gt_high,
  input  wire logic                    i_rectified_voltage_gt_max,
  // Coil detection and alert conditions
  input  wire logic                    i_coil_above_min,
  input  wire logic                    i_over_current,
  input  wire logic                    i_over_temp,
  input  wire logic                    i_wrong_network,
  input  wire logic                    i_local_fault,
  // Link and transmitter commands
  input  wire logic                    i_connected,
  input  wire logic                    i_charge_done,
  input  wire logic                    i_ctrl_write,
  input  wire logic                    i_ctrl_enable,
  input  wire logic                    i_ctrl_permit,
  input  wire logic                    i_ctrl_reduce,
  input  wire logic                    i_expected_msg,
  input  wire logic                    i_reconnect_failed,
  input  wire logic                    i_hv_reported,
  // Status and actions
  output logic [3:0]                   o_state,
  output logic [3:0]                   o_substate,
  output logic [`RXSC_ERR_W-1:0]       o_error_code,
  output logic                         o_charge_en,
  output logic                         o_power_limit,
  output logic                         o_hv_hold,
  output logic                         o_comm_en,
  output logic                         o_advertise,
  output logic                         o_alert,
  output logic                         o_reconnect,
  output logic                         o_terminate
);

  rxsc_tick_if   tick_if ();
  rxsc_regs_type r_ff;
  rxsc_regs_type nxt_r;
  logic          tick;
  logic          err_now;
  logic [`RXSC_ERR_W-1:0] err_code_now;

  rxsc_tick #(
    .CYCLES  (TICK_CYCLES)
  ) u_tick (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .tick_if (tick_if)
  );

  assign tick = tick_if.tick;

  // Local faults are absent here by design: only these reach System Error
  always_comb begin
    err_now      = i_rectified_voltage_gt_max | i_over_temp | i_over_current | i_wrong_network;
    err_code_now = `RXSC_ERR_NONE;
    if (i_rectified_voltage_gt_max) begin
      err_code_now = `RXSC_ERR_OVER_VOLT;
    end else if (i_over_temp) begin
      err_code_now = `RXSC_ERR_OVER_TEMP;
    end else if (i_over_current) begin
      err_code_now = `RXSC_ERR_OVER_CURR;
    end else if (i_wrong_network) begin
      err_code_now = `RXSC_ERR_WRONG_NET;
    end
  end

  always_comb begin
    nxt_r           = r_ff;
    nxt_r.adv       = 1'b0;
    nxt_r.alert     = 1'b0;
    nxt_r.reconnect = 1'b0;
    nxt_r.terminate = 1'b0;
    nxt_r.conn_d    = i_connected;

    // State transitions; no path exists besides those listed
    case (r_ff.state)
      RXSC_NULL: begin
        if (i_rectified_voltage_ge_boot) begin
          nxt_r.state = RXSC_BOOT;
        end
      end
      RXSC_BOOT: begin
        if (!i_rectified_voltage_ge_boot || !i_rectified_voltage_ge_uvlo) begin
          nxt_r.state = RXSC_NULL;
        end else if (err_now) begin
          nxt_r.state = RXSC_SYSERR;
        end else if (i_ctrl_write) begin
          nxt_r.state = RXSC_ON;
        end
      end
      RXSC_ON: begin
        if (!i_rectified_voltage_ge_boot || !i_rectified_voltage_ge_uvlo) begin
          nxt_r.state = RXSC_NULL;
        end else if (err_now) begin
          nxt_r.state = RXSC_SYSERR;
        end else if (i_charge_done && r_ff.conn_d && !i_connected) begin
          nxt_r.state = RXSC_BOOT;
        end
      end
      RXSC_SYSERR: begin
        if (!i_rectified_voltage_ge_boot || !i_rectified_voltage_ge_uvlo) begin
          nxt_r.state = RXSC_NULL;
        end
      end
      default: begin
        nxt_r.state = RXSC_NULL;
      end
    endcase

    // Code is latched on entry and alert goes out at once
    if (nxt_r.state == RXSC_SYSERR && r_ff.state != RXSC_SYSERR) begin
      nxt_r.err_code = err_code_now;
      nxt_r.alert    = 1'b1;
    end else if (nxt_r.state != RXSC_SYSERR) begin
      nxt_r.err_code = `RXSC_ERR_NONE;
    end

    // Control value from the transmitter
    if (nxt_r.state == RXSC_NULL) begin
      nxt_r.ctrl_en  = 1'b0;
      nxt_r.permit   = 1'b0;
      nxt_r.reduce   = 1'b0;
      nxt_r.out_kill = 1'b0;
    end else if (i_ctrl_write) begin
      nxt_r.ctrl_en  = i_ctrl_enable;
      nxt_r.permit   = i_ctrl_permit;
      nxt_r.reduce   = i_ctrl_reduce;
      nxt_r.out_kill = 1'b0;
    end

    // Voltage sub-state, only meaningful while on
    nxt_r.sub = RXSC_SUB_NONE;
    if (nxt_r.state == RXSC_ON) begin
      if (!i_rectified_voltage_ge_min) begin
        nxt_r.sub = RXSC_SUB_LOW;
      end else if (!i_rectified_voltage_gt_high) begin
        nxt_r.sub = RXSC_SUB_OPT;
      end else if (!i_rectified_voltage_gt_max) begin
        nxt_r.sub = RXSC_SUB_HIGH;
      end
    end

    // High voltage grace time starts when the sub-state is reported
    if (nxt_r.sub != RXSC_SUB_HIGH) begin
      nxt_r.hv_run  = 1'b0;
      nxt_r.hv_done = 1'b0;
      nxt_r.hv_cnt  = '0;
    end else if (!r_ff.hv_run && i_hv_reported) begin
      nxt_r.hv_run = 1'b1;
      nxt_r.hv_cnt = '0;
    end else if (r_ff.hv_run && !r_ff.hv_done && tick) begin
      nxt_r.hv_cnt = r_ff.hv_cnt + `RXSC_CNT_W'(1);
      if (r_ff.hv_cnt == `RXSC_CNT_W'(`RXSC_HV_HOLD_TICKS - 1)) begin
        nxt_r.hv_done = 1'b1;
      end
    end

    // Advertising while unlinked and powered
    if (r_ff.state == RXSC_BOOT && !i_connected && i_coil_above_min) begin
      if (tick && r_ff.cont_cnt != `RXSC_CNT_W'(`RXSC_ADV_DONE_TICKS)) begin
        nxt_r.cont_cnt = r_ff.cont_cnt + `RXSC_CNT_W'(1);
      end
      if (!i_charge_done) begin
        nxt_r.adv = 1'b1;
      end else if (r_ff.cont_cnt == `RXSC_CNT_W'(`RXSC_ADV_DONE_TICKS)) begin
        nxt_r.adv = 1'b1;
      end
    end else begin
      nxt_r.cont_cnt = '0;
    end

    // Link supervision
    if (!i_connected) begin
      nxt_r.sup_run = 1'b0;
      nxt_r.sup_cnt = '0;
    end else if ((i_connected && !r_ff.conn_d) || i_expected_msg) begin
      nxt_r.sup_run = 1'b1;
      nxt_r.sup_cnt = '0;
    end else if (r_ff.sup_run && tick) begin
      nxt_r.sup_cnt = r_ff.sup_cnt + `RXSC_CNT_W'(1);
      if (r_ff.sup_cnt == `RXSC_CNT_W'(`RXSC_LINK_SUP_TICKS - 1)) begin
        nxt_r.sup_run   = 1'b0;
        nxt_r.reconnect = 1'b1;
      end
    end
    if (i_reconnect_failed && nxt_r.state != RXSC_NULL) begin
      nxt_r.out_kill = 1'b1;
    end

    // Terminate the link once on loss of boot voltage
    if (i_rectified_voltage_ge_boot) begin
      nxt_r.term_sent = 1'b0;
    end else if (i_connected && !r_ff.term_sent) begin
      nxt_r.term_sent = 1'b1;
      nxt_r.terminate = 1'b1;
    end

    // Output gating follows the registered state of the same cycle
    nxt_r.charge_en = 1'b0;
    if (nxt_r.state == RXSC_ON) begin
      nxt_r.charge_en = nxt_r.ctrl_en && !nxt_r.out_kill && !i_local_fault
                        && !nxt_r.hv_done;
    end else if (nxt_r.state == RXSC_SYSERR) begin
      nxt_r.charge_en = nxt_r.ctrl_en && !nxt_r.out_kill
                        && (nxt_r.err_code == `RXSC_ERR_OVER_VOLT || !err_now);
    end
    nxt_r.comm_en = (nxt_r.state != RXSC_NULL);
    nxt_r.hv_hold   = nxt_r.hv_run && !nxt_r.hv_done;
    nxt_r.pwr_limit = !nxt_r.permit || nxt_r.reduce;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r_ff          <= '0;
      r_ff.state    <= RXSC_NULL;
      r_ff.sub      <= RXSC_SUB_NONE;
      r_ff.pwr_limit <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign o_state       = r_ff.state;
  assign o_substate    = r_ff.sub;
  assign o_error_code  = r_ff.err_code;
  assign o_charge_en   = r_ff.charge_en;
  assign o_hv_hold     = r_ff.hv_hold;
  assign o_power_limit = r_ff.pwr_limit;
  assign o_comm_en     = r_ff.comm_en;
  assign o_advertise   = r_ff.adv;
  assign o_alert       = r_ff.alert;
  assign o_reconnect   = r_ff.reconnect;
  assign o_terminate   = r_ff.terminate;

  AST_NULL_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (r_ff.state == RXSC_NULL && !i_rectified_voltage_ge_boot) |=> (r_ff.state == RXSC_NULL))
    else $error("left Null below boot threshold");

  AST_UVLO_NULL: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (r_ff.state != RXSC_NULL && !i_rectified_voltage_ge_uvlo) |=> (r_ff.state == RXSC_NULL))
    else $error("no return to Null under lockout");

  AST_OUT_OFF_EARLY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (r_ff.state == RXSC_NULL || r_ff.state == RXSC_BOOT) |-> !o_charge_en)
    else $error("charge output on before On");

  AST_ADV_FAST: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (r_ff.state == RXSC_BOOT && !i_connected && i_coil_above_min && !i_charge_done)
      |=> o_advertise)
    else $error("advertisement late");

  AST_SYSERR_ENTRY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ((r_ff.state == RXSC_BOOT || r_ff.state == RXSC_ON) && i_rectified_voltage_ge_boot && i_rectified_voltage_ge_uvlo
      && (i_rectified_voltage_gt_max || i_over_current || i_over_temp))
      |=> (r_ff.state == RXSC_SYSERR))
    else $error("System Error not entered");

  AST_SYSERR_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (r_ff.state == RXSC_SYSERR && r_ff.err_code != `RXSC_ERR_OVER_VOLT && $past(err_now))
      |-> !o_charge_en)
    else $error("output on during System Error");

  AST_ALERT_ENTRY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(r_ff.state == RXSC_SYSERR) |-> (o_alert && o_error_code != `RXSC_ERR_NONE))
    else $error("no alert on System Error entry");

  AST_SYSERR_EXIT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (r_ff.state == RXSC_SYSERR) |=> (r_ff.state == RXSC_SYSERR || r_ff.state == RXSC_NULL))
    else $error("illegal exit from System Error");

  AST_HIGH_SUB: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (r_ff.state == RXSC_ON && i_rectified_voltage_ge_min && i_rectified_voltage_gt_high && !i_rectified_voltage_gt_max)
      ##1 (r_ff.state == RXSC_ON) |-> (r_ff.sub == RXSC_SUB_HIGH))
    else $error("High Voltage sub-state missed");

  AST_BOOT_ON: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (r_ff.state == RXSC_BOOT && i_ctrl_write && !err_now && i_rectified_voltage_ge_boot && i_rectified_voltage_ge_uvlo)
      |=> (r_ff.state == RXSC_ON))
    else $error("Boot did not go On");

endmodule

`default_nettype wire

// ---- bench/rxsc_tx_model.sv ----
`timescale 1ns/100ps
`default_nettype none

// Transmitter side: link level, control writes and link messages
module rxsc_tx_model (
  // Clock
  input  wire logic i_clk,
  // Link and commands
  output logic      o_connected,
  output logic      o_charge_done,
  output logic      o_ctrl_write,
  output logic      o_ctrl_enable,
  output logic      o_ctrl_permit,
  output logic      o_ctrl_reduce,
  output logic      o_expected_msg,
  output logic      o_reconnect_failed
);
  initial begin
    o_connected        = 1'b0;
    o_charge_done      = 1'b0;
    o_ctrl_write       = 1'b0;
    o_expected_msg     = 1'b0;
    o_reconnect_failed = 1'b0;
    o_ctrl_enable      = 1'b0;
    o_ctrl_permit      = 1'b0;
    o_ctrl_reduce      = 1'b0;
  end

  task automatic link(input logic up);
    @(negedge i_clk);
    o_connected = up;
  endtask

  task automatic set_done(input logic d);
    @(negedge i_clk);
    o_charge_done = d;
  endtask

  // Qualifiers are only valid with the strobe, so they are inverted afterwards
  task automatic write_ctrl(input logic en, input logic pm, input logic rd);
    @(negedge i_clk);
    o_ctrl_enable = en;
    o_ctrl_permit = pm;
    o_ctrl_reduce = rd;
    o_ctrl_write  = 1'b1;
    @(negedge i_clk);
    o_ctrl_write  = 1'b0;
    o_ctrl_enable = !en;
    o_ctrl_permit = !pm;
    o_ctrl_reduce = !rd;
  endtask

  task automatic send_msg(input logic fail);
    @(negedge i_clk);
    if (fail) o_reconnect_failed = 1'b1;
    else o_expected_msg = 1'b1;
    @(negedge i_clk);
    {o_expected_msg, o_reconnect_failed} = 2'h0;
  endtask
endmodule

`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "rxsc_consts.svh"

module tb
  import rxsc_pkg::*;
;
  localparam int TK = 4;
  logic                   clk, rst_n, boot, uvlo, vmin, vhigh, vmax, coil, oc, ot, wnet, lfault, hvrep;
  logic                   conn, cdone, cw, cen, cpm, crd, msg, rfail;
  logic [3:0]             state, sub;
  logic [`RXSC_ERR_W-1:0] code;
  logic                   chg, lim, hold, comm, adv, alert, recon, term;
  int                     n_mismatch, samples_checked, cyc;
  wire  [3:0]             watch = {term, chg, recon, adv};

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  rxsc_top #(.TICK_CYCLES(TK)) i_dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_rectified_voltage_ge_boot(boot), .i_rectified_voltage_ge_uvlo(uvlo),
    .i_rectified_voltage_ge_min(vmin), .i_rectified_voltage_gt_high(vhigh), .i_rectified_voltage_gt_max(vmax),
    .i_coil_above_min(coil), .i_over_current(oc), .i_over_temp(ot), .i_wrong_network(wnet),
    .i_local_fault(lfault), .i_connected(conn), .i_charge_done(cdone), .i_ctrl_write(cw),
    .i_ctrl_enable(cen), .i_ctrl_permit(cpm), .i_ctrl_reduce(crd), .i_expected_msg(msg),
    .i_reconnect_failed(rfail), .i_hv_reported(hvrep), .o_state(state), .o_substate(sub),
    .o_error_code(code), .o_charge_en(chg), .o_power_limit(lim), .o_hv_hold(hold),
    .o_comm_en(comm), .o_advertise(adv), .o_alert(alert), .o_reconnect(recon), .o_terminate(term));

  rxsc_tx_model i_tx (
    .i_clk(clk), .o_connected(conn), .o_charge_done(cdone), .o_ctrl_write(cw),
    .o_ctrl_enable(cen), .o_ctrl_permit(cpm), .o_ctrl_reduce(crd), .o_expected_msg(msg),
    .o_reconnect_failed(rfail));

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("n_mismatch %0d samples_checked %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Bounded wait for one watched output to reach a level; n is cycles spent
  task automatic wait_bit(input int w, input logic v, input int lim, output int n);
    n = 0;
    while (watch[w] !== v && n < lim) begin
      step(1);
      n++;
    end
  endtask

  task automatic power(input logic on);
    {boot, uvlo} = {on, on};
    step(1);
  endtask

  task automatic t_reset();
    check("state", state, 8'h01);
    check("charge_en", chg, 8'h00);
    check("power_limit", lim, 8'h01);
    rst_n = 1'b1;
    step(5);
    check("state", state, 8'h01);
  endtask

  task automatic t_boot_on();
    power(1'b1);
    check("state", state, 8'h02);
    check("comm_en", comm, 8'h01);
    coil = 1'b1;
    step(1);
    check("advertise", adv, 8'h01);
    i_tx.link(1'b1);
    step(2);
    check("advertise", adv, 8'h00);
    i_tx.write_ctrl(1'b1, 1'b1, 1'b0);
    check("state", state, 8'h04);
    check("charge_en", chg, 8'h01);
    check("power_limit", lim, 8'h00);
    i_tx.write_ctrl(1'b1, 1'b1, 1'b1);
    check("power_limit", lim, 8'h01);
    i_tx.write_ctrl(1'b1, 1'b0, 1'b0);
    check("power_limit", lim, 8'h01);
    step(1);
    check("substate", sub, 8'h02);
    vmin = 1'b1;
    step(1);
    check("substate", sub, 8'h04);
    vhigh = 1'b1;
    step(1);
    check("substate", sub, 8'h08);
  endtask

  task automatic t_hv();
    int n;
    hvrep = 1'b1;
    step(1);
    hvrep = 1'b0;
    check("hv_hold", hold, 8'h01);
    step(4990 * TK);
    check("charge_en", chg, 8'h01);
    wait_bit(2, 1'b0, 20 * TK, n);
    check("hv_release", chg, 8'h00);
    check("hv_hold", hold, 8'h00);
    vhigh = 1'b0;
    i_tx.write_ctrl(1'b1, 1'b1, 1'b0);
  endtask

  task automatic t_sup();
    int n;
    i_tx.send_msg(1'b0);
    wait_bit(1, 1'b1, 1100 * TK, n);
    check("sup_window", 8'(n > 998 * TK && n <= 1002 * TK), 8'h01);
    i_tx.send_msg(1'b1);
    check("charge_en", chg, 8'h00);
    i_tx.write_ctrl(1'b1, 1'b1, 1'b0);
    lfault = 1'b1;
    step(2);
    check("state", state, 8'h04);
    check("comm_en", comm, 8'h01);
    check("charge_en", chg, 8'h00);
    check("error_code", code, 8'h00);
    lfault = 1'b0;
  endtask

  task automatic t_done();
    int n;
    i_tx.set_done(1'b1);
    i_tx.link(1'b0);
    step(1);
    check("state", state, 8'h02);
    check("charge_en", chg, 8'h00);
    coil = 1'b0;
    step(2);
    coil = 1'b1;
    step(300 * TK);
    coil = 1'b0;
    step(1);
    coil = 1'b1;
    step(590 * TK);
    check("advertise", adv, 8'h00);
    wait_bit(0, 1'b1, 200 * TK, n);
    check("advertise", adv, 8'h01);
    coil = 1'b0;
    i_tx.set_done(1'b0);
    i_tx.link(1'b1);
    boot = 1'b0;
    step(1);
    check("terminate", term, 8'h01);
    check("state", state, 8'h01);
    step(1);
    check("terminate", term, 8'h00);
    power(1'b1);
    uvlo = 1'b0;
    step(1);
    check("state", state, 8'h01);
  endtask

  task automatic t_err();
    for (int k = 1; k <= 4; k++) begin
      power(1'b1);
      i_tx.write_ctrl(1'b1, 1'b1, 1'b0);
      vmax = (k == 1);
      ot   = (k == 2);
      oc   = (k == 3);
      wnet = (k == 4);
      step(1);
      check("state", state, 8'h08);
      check("error_code", code, 8'(k));
      check("alert", alert, 8'h01);
      check("charge_en", chg, 8'(k == 1));
      check("comm_en", comm, 8'h01);
      step(1);
      check("alert", alert, 8'h00);
      vmax = 1'b0;
      ot   = 1'b0;
      oc   = 1'b0;
      wnet = 1'b0;
      step(1);
      check("charge_en", chg, 8'h01);
      power(1'b0);
      check("state", state, 8'h01);
    end
  endtask

  // Reset in mid-run while charging: output must drop at once
  task automatic t_mid_reset();
    power(1'b1);
    i_tx.write_ctrl(1'b1, 1'b1, 1'b0);
    check("charge_en", chg, 8'h01);
    rst_n = 1'b0;
    step(1);
    check("state", state, 8'h01);
    check("charge_en", chg, 8'h00);
    check("power_limit", lim, 8'h01);
    rst_n = 1'b1;
    step(1);
    check("state", state, 8'h02);
    check("charge_en", chg, 8'h00);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      stop_test();
    end
  end

  initial begin
    {rst_n, boot, uvlo, vmin, vhigh, vmax, coil, oc, ot, wnet, lfault, hvrep} = 12'h000;
    n_mismatch = 0;
    samples_checked = 0;
    cyc = 0;
    step(16);
    t_reset();
    t_boot_on();
    t_hv();
    t_sup();
    t_done();
    t_err();
    t_mid_reset();
    stop_test();
  end
endmodule

`default_nettype wire
